// ===== inc/ausb_pkg.sv
// Constants and types shared by the asynchronous serial block
package ausb_pkg;

	// Register byte addresses
	localparam logic [15:0] MODE_ADDR = 16'hffa0;
	localparam logic [15:0] STATUS_ADDR = 16'hffa1;
	localparam logic [15:0] BAUD_ADDR = 16'hffa2;
	localparam logic [15:0] DATA_ADDR = 16'hffa3;

	// Values after reset
	localparam logic [7:0] MODE_RESET = 8'h00;
	localparam logic [2:0] STATUS_RESET = 3'h0;
	localparam logic [6:0] BAUD_RESET = 7'h00;
	localparam logic [7:0] TX_SHIFT_RESET = 8'hff;
	localparam logic [7:0] RX_BUFFER_RESET = 8'hff;

	// Mode register fields
	localparam int TX_ENABLE_BIT = 7;
	localparam int RX_ENABLE_BIT = 6;
	localparam int PARITY_SEL_HI = 5;
	localparam int PARITY_SEL_LO = 4;
	localparam int CHAR_LEN_SEL = 3;
	localparam int STOP_LEN_SEL = 2;
	localparam int ERR_IRQ_SUPPRESS = 1;

	// Status register fields
	localparam int PARITY_ERR_FLAG = 2;
	localparam int FRAME_ERR_FLAG = 1;
	localparam int OVERRUN_ERR_FLAG = 0;

	// Baud generator fields and base divisor
	localparam int PRESCALE_SEL_LSB = 4;
	localparam logic [4:0] DIVISOR_BASE = 5'h10;

	// Parity modes
	localparam logic [1:0] PAR_NONE = 2'h0;
	localparam logic [1:0] PAR_ZERO = 2'h1;
	localparam logic [1:0] PAR_ODD = 2'h2;
	localparam logic [1:0] PAR_EVEN = 2'h3;

	typedef enum logic [4:0] {
		TX_IDLE = 5'h01,
		TX_START = 5'h02,
		TX_DATA = 5'h04,
		TX_PAR = 5'h08,
		TX_STOP = 5'h10
	} ausb_tx_state_t;

	typedef enum logic [4:0] {
		RX_IDLE = 5'h01,
		RX_START = 5'h02,
		RX_DATA = 5'h04,
		RX_PAR = 5'h08,
		RX_STOP = 5'h10
	} ausb_rx_state_t;

endpackage

// ===== logic/ausb_uart.sv
// Asynchronous serial transmitter/receiver with baud generator and register port
//
// Behaviour
// - 7-bit mode sends data bits 0..6 only
// - Writing the data address queues a character; transmission starts once the transmitter is enabled and idle
// - Transmit shift register write-only, resets FFH
// - Data address reads receive, writes transmit
// - Shifted-in character moves to receive buffer
// - 7-bit receive forces buffer bit 7 zero
// - Receive buffer read-only, resets FFH
// - Transmit frames start, parity, stop bits
// - Receive errors set matching status flags
// - Mode register read/write, resets 00H
// - Bits 7/6 enable transmit and receive
// - Bits 5:4 select parity mode
// - Bit 3 selects seven or eight bits
// - Bit 2 selects one or two stops
// - Bit 1 suppresses completion request on error
// - Status read-only, bits 2..0 flags
// - Parity mismatch in odd or even mode sets parity error flag
// - Missing stop bit sets framing error
// - Unread buffer at completion sets overrun
// - Receiver checks only one stop bit
// - Prescale 2..256 then divide 16..31
`timescale 1ns/100ps
`default_nettype none

module ausb_uart
	import ausb_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	// Processor register port
	input wire logic [15:0] bus_addr_in,
	input wire logic bus_wr_in,
	input wire logic bus_rd_in,
	input wire logic [7:0] bus_wdata_in,
	output logic [7:0] bus_rdata_out,
	output logic tx_space_out,
	// Serial pins
	input wire logic serial_in_pin_in,
	output logic serial_out_pin_out,
	output logic tx_pin_serial_out,
	output logic rx_pin_serial_out,
	// Reception-complete request
	output logic rx_done_irq_out
);

	typedef struct packed {
		logic [7:0] mode_reg;
		logic [6:0] baud_gen_ctrl_reg;
		logic [2:0] status_reg;
		logic [7:0] rx_buffer;
		logic unread;
		logic [7:0] rdata;
		logic irq;
		logic [1:0][7:0] fifo_mem;
		logic fifo_wp;
		logic fifo_rp;
		logic [1:0] fifo_cnt;
		logic space;
		logic [7:0] pre_cnt;
		ausb_tx_state_t tx_state;
		logic [7:0] tx_shift_reg;
		logic [4:0] tx_cnt;
		logic [2:0] tx_bit;
		logic tx_stop2;
		logic txd;
		logic [2:0] sync;
		logic line;
		ausb_rx_state_t rx_state;
		logic [7:0] rx_shift_reg;
		logic [4:0] rx_cnt;
		logic [2:0] rx_bit;
		logic rx_par;
	} ausb_state_t;

	localparam ausb_state_t STATE_RESET = '{
		mode_reg: MODE_RESET, baud_gen_ctrl_reg: BAUD_RESET, status_reg: STATUS_RESET,
		rx_buffer: RX_BUFFER_RESET, unread: 1'b0, rdata: 8'h00, irq: 1'b0,
		fifo_mem: '0, fifo_wp: 1'b0, fifo_rp: 1'b0, fifo_cnt: 2'h0, space: 1'b1,
		pre_cnt: 8'h00, tx_state: TX_IDLE, tx_shift_reg: TX_SHIFT_RESET, tx_cnt: 5'h00,
		tx_bit: 3'h0, tx_stop2: 1'b0, txd: 1'b1, sync: 3'h7, line: 1'b1,
		rx_state: RX_IDLE, rx_shift_reg: 8'h00, rx_cnt: 5'h00, rx_bit: 3'h0, rx_par: 1'b0
	};

	ausb_state_t st_reg;
	ausb_state_t st_next;

	logic tx_en, rx_en, len8, sck_tick, wr_data, rd_data, push, pop;
	logic par_calc, par_err, frame_err;
	logic [1:0] par_mode;
	logic [2:0] last_bit;
	logic [7:0] pre_mask, rx_char;
	logic [4:0] bit_lim, half_lim;

	assign tx_en = st_reg.mode_reg[TX_ENABLE_BIT];
	assign rx_en = st_reg.mode_reg[RX_ENABLE_BIT];
	assign par_mode = st_reg.mode_reg[PARITY_SEL_HI:PARITY_SEL_LO];
	assign len8 = st_reg.mode_reg[CHAR_LEN_SEL];
	assign last_bit = len8 ? 3'h7 : 3'h6;
	// prescaler gives fx/2^(n+1), then 16+m count
	assign pre_mask = 8'((9'h002 << st_reg.baud_gen_ctrl_reg[6:PRESCALE_SEL_LSB]) - 9'h001);
	assign sck_tick = &(st_reg.pre_cnt | ~pre_mask);
	assign bit_lim = DIVISOR_BASE + {1'b0, st_reg.baud_gen_ctrl_reg[3:0]} - 5'h01;
	assign half_lim = ((DIVISOR_BASE + {1'b0, st_reg.baud_gen_ctrl_reg[3:0]}) >> 1) - 5'h01;

	// shared address, direction picks the register
	assign wr_data = bus_wr_in && (bus_addr_in == DATA_ADDR);
	assign rd_data = bus_rd_in && (bus_addr_in == DATA_ADDR);
	// A full buffer drops the write; tx_space_out tells software to wait
	assign push = wr_data && (st_reg.fifo_cnt != 2'h2);
	assign pop = tx_en && (st_reg.tx_state == TX_IDLE) && (st_reg.fifo_cnt != 2'h0);
	// seven-bit characters land in the top seven shifted bits
	assign rx_char = len8 ? st_reg.rx_shift_reg : {1'b0, st_reg.rx_shift_reg[7:1]};
	assign par_calc = (par_mode == PAR_ODD) ? ~(^rx_char) : ^rx_char;
	// only odd and even modes are checked
	assign par_err = par_mode[1] && (st_reg.rx_par != par_calc);
	assign frame_err = !st_reg.line;

	always_comb
	begin
		st_next = st_reg;
		st_next.irq = 1'b0;
		st_next.pre_cnt = st_reg.pre_cnt + 8'h01;
		// mode register, bit 0 kept as written
		if (bus_wr_in && (bus_addr_in == MODE_ADDR))
		begin
			st_next.mode_reg = bus_wdata_in;
		end
		if (bus_wr_in && (bus_addr_in == BAUD_ADDR))
		begin
			st_next.baud_gen_ctrl_reg = bus_wdata_in[6:0];
		end
		// Read data is registered, valid the cycle after the strobe
		if (bus_rd_in)
		begin
			unique case (bus_addr_in)
				MODE_ADDR: st_next.rdata = st_reg.mode_reg;
				STATUS_ADDR: st_next.rdata = {5'h00, st_reg.status_reg};
				BAUD_ADDR: st_next.rdata = {1'b0, st_reg.baud_gen_ctrl_reg};
				DATA_ADDR: st_next.rdata = st_reg.rx_buffer;
				default: st_next.rdata = 8'h00;
			endcase
		end
		if (rd_data)
		begin
			st_next.unread = 1'b0;
		end
		// a write queues the character, transmitter takes it when idle
		if (push)
		begin
			st_next.fifo_mem[st_reg.fifo_wp] = bus_wdata_in;
			st_next.fifo_wp = ~st_reg.fifo_wp;
		end
		if (pop)
		begin
			st_next.fifo_rp = ~st_reg.fifo_rp;
		end
		st_next.fifo_cnt = st_reg.fifo_cnt + {1'b0, push} - {1'b0, pop};
		st_next.space = (st_next.fifo_cnt != 2'h2);
		unique case (st_reg.tx_state)
			TX_IDLE:
			begin
				st_next.txd = 1'b1;
				if (pop)
				begin
					// write-only shift register loaded from queue
					st_next.tx_shift_reg = st_reg.fifo_mem[st_reg.fifo_rp];
					st_next.tx_state = TX_START;
					st_next.tx_cnt = 5'h00;
					st_next.txd = 1'b0;
				end
			end
			TX_START, TX_DATA, TX_PAR, TX_STOP:
			begin
				if (sck_tick)
				begin
					st_next.tx_cnt = st_reg.tx_cnt + 5'h01;
				end
				if (sck_tick && (st_reg.tx_cnt == bit_lim))
				begin
					st_next.tx_cnt = 5'h00;
					unique case (st_reg.tx_state)
						TX_START:
						begin
							st_next.tx_state = TX_DATA;
							st_next.tx_bit = 3'h0;
							st_next.txd = st_reg.tx_shift_reg[0];
						end
						TX_DATA:
						begin
							// stop after bit 6 in 7-bit mode
							if (st_reg.tx_bit == last_bit)
							begin
								if (par_mode == PAR_NONE)
								begin
									st_next.tx_state = TX_STOP;
									st_next.txd = 1'b1;
								end
								else
								begin
									st_next.tx_state = TX_PAR;
									unique case (par_mode)
										PAR_ZERO: st_next.txd = 1'b0;
										PAR_ODD: st_next.txd = ~(^(st_reg.tx_shift_reg & {len8, 7'h7f}));
										default: st_next.txd = ^(st_reg.tx_shift_reg & {len8, 7'h7f});
									endcase
								end
								st_next.tx_stop2 = st_reg.mode_reg[STOP_LEN_SEL];
							end
							else
							begin
								st_next.tx_bit = st_reg.tx_bit + 3'h1;
								st_next.txd = st_reg.tx_shift_reg[st_reg.tx_bit + 3'h1];
							end
						end
						TX_PAR:
						begin
							st_next.tx_state = TX_STOP;
							st_next.txd = 1'b1;
						end
						default:
						begin
							st_next.txd = 1'b1;
							if (st_reg.tx_stop2)
							begin
								st_next.tx_stop2 = 1'b0;
							end
							else
							begin
								st_next.tx_state = TX_IDLE;
							end
						end
					endcase
				end
			end
		endcase
		// transmitter disabled holds the line idle
		if (!tx_en)
		begin
			st_next.tx_state = TX_IDLE;
			st_next.txd = 1'b1;
		end

		// Three-stage sampler; a change counts once stages two and three agree
		st_next.sync = {st_reg.sync[1:0], serial_in_pin_in};
		if (st_reg.sync[2] == st_reg.sync[1])
		begin
			st_next.line = st_reg.sync[2];
		end

		if (sck_tick && (st_reg.rx_state != RX_IDLE))
		begin
			st_next.rx_cnt = st_reg.rx_cnt + 5'h01;
		end
		unique case (st_reg.rx_state)
			RX_IDLE:
			begin
				// falling start edge restarts bit timing
				if (!st_reg.line)
				begin
					st_next.rx_state = RX_START;
					st_next.rx_cnt = 5'h00;
				end
			end
			RX_START:
			begin
				// centre check of start bit rejects glitches
				if (sck_tick && (st_reg.rx_cnt == half_lim))
				begin
					st_next.rx_cnt = 5'h00;
					st_next.rx_bit = 3'h0;
					st_next.rx_state = st_reg.line ? RX_IDLE : RX_DATA;
				end
			end
			RX_DATA, RX_PAR, RX_STOP:
			begin
				if (sck_tick && (st_reg.rx_cnt == bit_lim))
				begin
					st_next.rx_cnt = 5'h00;
					unique case (st_reg.rx_state)
						RX_DATA:
						begin
							st_next.rx_shift_reg = {st_reg.line, st_reg.rx_shift_reg[7:1]};
							st_next.rx_bit = st_reg.rx_bit + 3'h1;
							if (st_reg.rx_bit == last_bit)
							begin
								st_next.rx_state = (par_mode == PAR_NONE) ? RX_STOP : RX_PAR;
							end
						end
						RX_PAR:
						begin
							st_next.rx_par = st_reg.line;
							st_next.rx_state = RX_STOP;
						end
						default:
						begin
							// a single stop bit is checked
							st_next.rx_state = RX_IDLE;
							st_next.rx_buffer = rx_char;
							st_next.status_reg[PARITY_ERR_FLAG] = par_err;
							st_next.status_reg[FRAME_ERR_FLAG] = frame_err;
							st_next.status_reg[OVERRUN_ERR_FLAG] = st_reg.unread;
							// Completion beats a same-cycle read so the new data stays unread
							st_next.unread = 1'b1;
							// request dropped on error when suppressed
							st_next.irq = !(st_reg.mode_reg[ERR_IRQ_SUPPRESS]
								&& (par_err || frame_err || st_reg.unread));
						end
					endcase
				end
			end
		endcase
		if (!rx_en)
		begin
			st_next.rx_state = RX_IDLE;
		end
	end

	always_ff @(posedge sys_clk_in)
	begin
		if (!rst_n_in)
		begin
			st_reg <= STATE_RESET;
		end
		else
		begin
			st_reg <= st_next;
		end
	end

	assign bus_rdata_out = st_reg.rdata;
	assign tx_space_out = st_reg.space;
	assign serial_out_pin_out = st_reg.txd;
	assign tx_pin_serial_out = st_reg.mode_reg[TX_ENABLE_BIT];
	assign rx_pin_serial_out = st_reg.mode_reg[RX_ENABLE_BIT];
	assign rx_done_irq_out = st_reg.irq;

endmodule

`default_nettype wire

// ===== sim/ausb_uart_assertions.sv
// Port assertions for the asynchronous serial block
`timescale 1ns/100ps
`default_nettype none
module ausb_uart_chk
	import ausb_pkg::*;
(
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic [15:0] bus_addr_in,
	input wire logic bus_wr_in,
	input wire logic bus_rd_in,
	input wire logic [7:0] bus_wdata_in,
	input wire logic [7:0] bus_rdata_out,
	input wire logic serial_out_pin_out,
	input wire logic tx_pin_serial_out,
	input wire logic rx_pin_serial_out,
	input wire logic rx_done_irq_out
);
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!rst_n_in);
	// Long high run proves the transmitter idle, so a write must start a frame at once
	logic [8:0] hi_cnt_reg;
	logic [8:0] hi_cnt_next;
	always_comb hi_cnt_next = !serial_out_pin_out ? 9'h000 :
		(hi_cnt_reg == 9'h1ff) ? hi_cnt_reg : hi_cnt_reg + 9'h001;
	always_ff @(posedge sys_clk_in) hi_cnt_reg <= !rst_n_in ? 9'h000 : hi_cnt_next;
	property p_tx_sel;
		bus_wr_in && bus_addr_in == MODE_ADDR |=> tx_pin_serial_out == $past(bus_wdata_in[7]);
	endproperty
	a_tx_sel: assert property (p_tx_sel) else $error("tx select wrong");
	property p_rx_sel;
		bus_wr_in && bus_addr_in == MODE_ADDR |=> rx_pin_serial_out == $past(bus_wdata_in[6]);
	endproperty
	a_rx_sel: assert property (p_rx_sel) else $error("rx select wrong");
	property p_stat_hi;
		bus_rd_in && bus_addr_in == STATUS_ADDR |=> bus_rdata_out[7:3] == 5'h00;
	endproperty
	a_stat_hi: assert property (p_stat_hi) else $error("status high bits set");
	property p_rd_hold;
		!bus_rd_in |=> $stable(bus_rdata_out);
	endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
	property p_start;
		bus_wr_in && bus_addr_in == DATA_ADDR && tx_pin_serial_out && hi_cnt_reg == 9'h1ff
			|-> ##[1:2] !serial_out_pin_out;
	endproperty
	a_start: assert property (p_start) else $error("no start bit");
	property p_irq_pulse;
		rx_done_irq_out |=> !rx_done_irq_out;
	endproperty
	a_irq_pulse: assert property (p_irq_pulse) else $error("request too long");
	property p_irq_en;
		rx_done_irq_out |-> $past(rx_pin_serial_out);
	endproperty
	a_irq_en: assert property (p_irq_en) else $error("request while rx off");
	property p_tx_off;
		!tx_pin_serial_out [*3] |-> serial_out_pin_out;
	endproperty
	a_tx_off: assert property (p_tx_off) else $error("line low while tx off");
endmodule
bind ausb_uart ausb_uart_chk u_chk (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
	.bus_addr_in(bus_addr_in), .bus_wr_in(bus_wr_in), .bus_rd_in(bus_rd_in),
	.bus_wdata_in(bus_wdata_in), .bus_rdata_out(bus_rdata_out),
	.serial_out_pin_out(serial_out_pin_out), .tx_pin_serial_out(tx_pin_serial_out),
	.rx_pin_serial_out(rx_pin_serial_out), .rx_done_irq_out(rx_done_irq_out));
`default_nettype wire

// ===== sim/ausb_peer.sv
// Remote serial transceiver model on the two line wires
`timescale 1ns/100ps
`default_nettype none
module ausb_peer
(
	input wire logic clk_in,
	input wire logic line_in,
	output logic line_out
);
	// Bit time in clocks; the bench changes it together with the rate
	int bit_clks = 32;
	initial line_out = 1'b1;
	// bit 0 first; last bit held just past its centre so no false start follows
	task automatic send(input logic [11:0] f, input int len);
		for (int i = 0; i < len; i++)
		begin
			@(posedge clk_in) #1 line_out = f[i];
			repeat ((i == len - 1) ? bit_clks / 2 + 7 : bit_clks - 1) @(posedge clk_in);
		end
		#1 line_out = 1'b1;
		repeat (bit_clks) @(posedge clk_in);
	endtask
	// Samples on the falling edge to stay clear of the launch edge
	task automatic grab(input int len, output logic [11:0] f);
		int t;
		f = 12'hfff;
		t = 0;
		while (line_in !== 1'b0 && t < 3000)
		begin
			@(negedge clk_in);
			t++;
		end
		repeat (bit_clks / 2) @(negedge clk_in);
		for (int i = 0; i < len; i++)
		begin
			f[i] = line_in;
			repeat ((i < len - 1) ? bit_clks : 0) @(negedge clk_in);
		end
	endtask
endmodule
`default_nettype wire

// ===== sim/test_async_serial_uart_with_baud_gen.sv
// Self-checking bench for the asynchronous serial block
`timescale 1ns/100ps
`default_nettype none
module test_async_serial_uart_with_baud_gen
	import ausb_pkg::*;
;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [15:0] addr = 16'h0000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] wdata = 8'h00;
	logic [7:0] rdata;
	logic space;
	logic rx_line;
	logic tx_line;
	logic irq;
	int n_fail = 0;
	int checks_done = 0;
	int n_irq = 0;
	always #20 clk = ~clk;
	always @(posedge clk) n_irq <= n_irq + int'(irq === 1'b1);
	ausb_uart u_dut (.sys_clk_in(clk), .rst_n_in(rst_n), .bus_addr_in(addr), .bus_wr_in(wr),
		.bus_rd_in(rd), .bus_wdata_in(wdata), .bus_rdata_out(rdata), .tx_space_out(space),
		.serial_in_pin_in(rx_line), .serial_out_pin_out(tx_line), .tx_pin_serial_out(),
		.rx_pin_serial_out(), .rx_done_irq_out(irq));
	// transmit line in, receive line out
	ausb_peer u_peer (.clk_in(clk), .line_in(tx_line), .line_out(rx_line));
	task automatic stop_test;
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			n_fail++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk) #1 addr = a;
		wdata = d;
		wr = 1'b1;
		@(posedge clk) #1 wr = 1'b0;
	endtask
	task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
		@(posedge clk) #1 addr = a;
		rd = 1'b1;
		@(posedge clk) #1 rd = 1'b0;
		chk({4'h0, rdata}, {4'h0, exp});
	endtask
	// every mode value keeps bit 0 clear
	// stop both directions before a new mode
	task automatic set_mode(input logic [7:0] m);
		wr_reg(MODE_ADDR, 8'h00);
		wr_reg(MODE_ADDR, m);
	endtask
	function automatic int flen(input logic [7:0] m);
		return (m[3] ? 9 : 8) + int'(m[5:4] != PAR_NONE) + (m[2] ? 2 : 1);
	endfunction
	function automatic logic [11:0] frame(input logic [7:0] d, input logic [7:0] m);
		logic [11:0] f;
		int k;
		logic p;
		f = 12'hffe;
		k = m[3] ? 8 : 7;
		p = ^(d & (m[3] ? 8'hff : 8'h7f));
		for (int i = 0; i < k; i++)
			f[i + 1] = d[i];
		// zero, odd or even parity after the data
		if (m[5:4] != PAR_NONE)
			f[k + 1] = (m[5:4] == PAR_ZERO) ? 1'b0 : (m[5:4] == PAR_ODD) ? ~p : p;
		return f;
	endfunction
	task automatic t_reset;
		rd_chk(MODE_ADDR, MODE_RESET);
		rd_chk(STATUS_ADDR, 8'h00);
		rd_chk(DATA_ADDR, RX_BUFFER_RESET);
		rd_chk(16'hffa4, 8'h00);
		chk({11'h000, tx_line}, 12'h001);
		wr_reg(MODE_ADDR, 8'h3e);
		wr_reg(STATUS_ADDR, 8'hff);
		rd_chk(MODE_ADDR, 8'h3e);
		rd_chk(STATUS_ADDR, 8'h00);
	endtask
	task automatic t_tx;
		logic [7:0] modes [4] = '{8'hbc, 8'ha0, 8'h98, 8'h88};
		logic [7:0] data [4] = '{8'h96, 8'hd5, 8'hff, 8'ha5};
		logic [11:0] f;
		for (int i = 0; i < 4; i++)
		begin
			set_mode(modes[i]);
			repeat (520) @(posedge clk);
			wr_reg(DATA_ADDR, data[i]);
			u_peer.grab(flen(modes[i]), f);
			chk(f, frame(data[i], modes[i]));
		end
	endtask
	// Fill the transmit queue until it refuses, then let the far side collect the three frames as the transmitter drains it
	task automatic t_queue;
		logic [7:0] q [3] = '{8'h3c, 8'hc3, 8'h5a};
		logic [11:0] f;
		set_mode(8'h88);
		for (int i = 0; i < 3; i++)
			wr_reg(DATA_ADDR, q[i]);
		// fourth write while full is dropped
		wr_reg(DATA_ADDR, 8'h00);
		chk({11'h000, space}, 12'h000);
		for (int i = 0; i < 3; i++)
		begin
			u_peer.grab(10, f);
			chk(f, frame(q[i], 8'h88));
		end
		repeat (40) @(posedge clk);
		chk({11'h000, space}, 12'h001);
		u_peer.grab(10, f);
		chk(f, 12'hfff);
	endtask
	task automatic t_rx(input logic [7:0] m, input logic [7:0] d, input logic [11:0] flip,
		input logic [7:0] st, input int irqs);
		int n0;
		set_mode(m);
		n0 = n_irq;
		u_peer.send(frame(d, m) ^ flip, flen(m) - (m[2] ? 1 : 0));
		chk(12'(n_irq - n0), 12'(irqs));
		rd_chk(STATUS_ADDR, st);
		rd_chk(DATA_ADDR, m[3] ? d : {1'b0, d[6:0]});
	endtask
	// prescale field 1, divisor field 1: 68 clocks a bit
	task automatic t_baud;
		logic [11:0] f;
		wr_reg(BAUD_ADDR, 8'h11);
		rd_chk(BAUD_ADDR, 8'h11);
		set_mode(8'hc8);
		u_peer.bit_clks = 68;
		wr_reg(DATA_ADDR, 8'h6b);
		u_peer.grab(10, f);
		chk(f, frame(8'h6b, 8'hc8));
		repeat (40) @(posedge clk);
		u_peer.send(frame(8'h4e, 8'hc8), 10);
		rd_chk(STATUS_ADDR, 8'h00);
		rd_chk(DATA_ADDR, 8'h4e);
		u_peer.bit_clks = 32;
		wr_reg(MODE_ADDR, 8'h00);
		wr_reg(BAUD_ADDR, 8'h00);
	endtask
	task automatic t_ovr;
		set_mode(8'h48);
		u_peer.send(frame(8'h01, 8'h48), 10);
		u_peer.send(frame(8'h02, 8'h48), 10);
		rd_chk(STATUS_ADDR, 8'h01);
		wr_reg(16'hffa4, 8'h00);
		rd_chk(DATA_ADDR, 8'h02);
		u_peer.send(frame(8'h03, 8'h48), 10);
		rd_chk(STATUS_ADDR, 8'h00);
	endtask
	initial
	begin
		repeat (3) @(posedge clk);
		#1 rst_n = 1'b1;
		t_reset;
		t_tx;
		t_queue;
		t_rx(8'h78, 8'h3c, 12'h000, 8'h00, 1);
		t_rx(8'h68, 8'h3d, 12'h200, 8'h04, 1);
		t_rx(8'h6a, 8'h3d, 12'h200, 8'h04, 0);
		t_rx(8'h58, 8'h81, 12'h200, 8'h00, 1);
		t_rx(8'h40, 8'hff, 12'h000, 8'h00, 1);
		t_rx(8'h4c, 8'h12, 12'h200, 8'h02, 1);
		t_baud;
		t_ovr;
		stop_test;
	end
	initial
	begin
		repeat (40000) @(posedge clk);
		n_fail++;
		stop_test;
	end
endmodule
`default_nettype wire
